// [include/ttrc_defs.vh]
// Purpose: constants for the trace trigger and record control block
// Assumes: one frame per target memory cycle, strobed by the pod
// Notes: a product term is a 15-bit care mask over a 15-bit value
`ifndef TTRC_DEFS_VH
`define TTRC_DEFS_VH
`define TTRC_FRAME_W 48
`define TTRC_NUM_EVT 8
`define TTRC_NUM_SBIT 6
`define TTRC_OPND_W 15
`define TTRC_TERM_W 30
`define TTRC_CHAIN_N 4
`define TTRC_DELAY_DFLT 32'h00008000
`define TTRC_LOOP_DFLT 16'h0000
`define TTRC_BRK_NONE 2'h0
`define TTRC_BRK_TRIG 2'h1
`define TTRC_BRK_DONE 2'h2
`define TTRC_BRK_STATE 2'h3
`define TTRC_REC_ALWAYS 2'h0
`define TTRC_REC_COND 2'h1
`define TTRC_REC_SOURCE 2'h2
`define TTRC_SB_LOOP 3
`define TTRC_SB_BREAK 2
`define TTRC_SB_CYCLE 5
`define TTRC_TS_WRAP 16'hFFFF
`endif

// [src/ttrc_trace_ctrl.v]
// Purpose: trigger, stop delay, loop counter, break, record filter,
//          timestamp and cycle counter of the advanced trace board
// Assumes: pod strobes and data are asynchronous and are synchronised here;
//          configuration ports are static while emulation runs
// Notes: expressions are sums of product terms over the 15 operands
`timescale 1ns/100ps
`include "ttrc_defs.vh"

module ttrc_trace_ctrl (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_frame_strobe,
  input wire [47:0] i_frame_data,
  input wire i_frame_is_source,
  input wire i_half_cycle,
  input wire i_emu_start,
  input wire [383:0] i_evt_care,
  input wire [383:0] i_evt_value,
  input wire [5:0] i_sbit_setclr,
  input wire [179:0] i_sbit_term_a,
  input wire [179:0] i_sbit_term_b,
  input wire i_trig_on,
  input wire [1:0] i_trig_last_step,
  input wire [119:0] i_trig_terms,
  input wire [31:0] i_trig_delay,
  input wire [15:0] i_loop_count,
  input wire [1:0] i_break_mode,
  input wire [1:0] i_record_mode,
  input wire [59:0] i_record_terms,
  input wire [3:0] i_filter_delay,
  input wire [16:0] i_ts_prescale,
  input wire i_ts_overflow_on,
  output reg o_capturing_ff,
  output reg o_triggered_ff,
  output reg o_store_ff,
  output reg [63:0] o_store_frame_ff,
  output reg o_break_req_ff,
  output reg o_loop_done_ff,
  output reg [5:0] o_state_bits_ff,
  output reg [31:0] o_cycle_count_ff,
  output reg o_cycle_gate_pin_ff
);

  // one product term: care mask in upper half, wanted value in lower half
  function term_true;
    input [`TTRC_OPND_W-1:0] opnd;
    input [`TTRC_TERM_W-1:0] term;
    begin
      term_true = ((opnd ^ term[`TTRC_OPND_W-1:0]) &
        term[`TTRC_TERM_W-1:`TTRC_OPND_W]) == {`TTRC_OPND_W{1'b0}};
    end
  endfunction

  // pod side synchronisers; stage 1 feeds only stage 2
  reg [2:0] strb_sync_ff;
  reg [2:0] half_sync_ff;
  reg [48:0] data_s1_ff;
  reg [48:0] data_s2_ff;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strb_sync_ff <= 3'h0;
      half_sync_ff <= 3'h0;
      data_s1_ff <= 49'h0;
      data_s2_ff <= 49'h0;
    end else begin
      strb_sync_ff <= {strb_sync_ff[1:0], i_frame_strobe};
      half_sync_ff <= {half_sync_ff[1:0], i_half_cycle};
      data_s1_ff <= {i_frame_is_source, i_frame_data};
      data_s2_ff <= data_s1_ff;
    end
  end
  wire frame_tick = strb_sync_ff[1] & ~strb_sync_ff[2];
  wire half_tick = half_sync_ff[1] & ~half_sync_ff[2];
  wire [47:0] frame = data_s2_ff[47:0];
  wire frame_src = data_s2_ff[48];

  wire [7:0] evt;
  genvar g;
  generate
    for (g = 0; g < `TTRC_NUM_EVT; g = g + 1) begin : g_evt
      assign evt[g] = ((frame ^ i_evt_value[g*48 +: 48]) &
        i_evt_care[g*48 +: 48]) == 48'h0;
    end
  endgenerate

  wire [14:0] opnd = {o_loop_done_ff, o_state_bits_ff, evt};

  wire [5:0] nxt_sbits;
  generate
    for (g = 0; g < `TTRC_NUM_SBIT; g = g + 1) begin : g_sbit
      wire ta = term_true(opnd, i_sbit_term_a[g*30 +: 30]);
      wire tb = term_true(opnd, i_sbit_term_b[g*30 +: 30]);
      assign nxt_sbits[g] = i_sbit_setclr[g] ?
        (ta | (o_state_bits_ff[g] & ~tb)) : (ta | tb);
    end
  endgenerate

  // chain step terms, unused steps beyond last are ignored
  reg [1:0] chain_step_ff;
  wire step_true = term_true(opnd, i_trig_terms[chain_step_ff*30 +: 30]);
  wire trig_now = i_trig_on & o_capturing_ff & ~o_triggered_ff &
    step_true & (chain_step_ff == i_trig_last_step);

  wire rec_expr = term_true(opnd, i_record_terms[29:0]) |
    term_true(opnd, i_record_terms[59:30]);

  reg rec_expr_d_ff;
  reg [3:0] filt_cnt_ff;
  reg [31:0] delay_cnt_ff;
  reg [15:0] loop_cnt_ff;
  reg [15:0] presc_ff;
  reg presc_phase_ff;
  reg [15:0] ts_ff;
  reg ovf_pend_ff;

  // first tail frame is taken at once; the counter holds the rest
  wire rec_tail = (rec_expr_d_ff & (i_filter_delay != 4'h0)) |
    (filt_cnt_ff != 4'h0);

  reg rec_ok;
  always @* begin
    case (i_record_mode)
      `TTRC_REC_ALWAYS: rec_ok = 1'b1;
      `TTRC_REC_COND: rec_ok = rec_expr | rec_tail;
      `TTRC_REC_SOURCE: rec_ok = frame_src;
      default: rec_ok = 1'b1;
    endcase
  end

  // even divide: N half cycles equals N/2 full cycles
  wire [15:0] presc_top = i_ts_prescale[16:1] - 16'h0001;
  wire no_presc = (i_ts_prescale[16:1] == 16'h0000);
  wire ts_adv = half_tick &
    (no_presc | (presc_phase_ff & (presc_ff == presc_top)));
  // wrap marks a pending forced frame
  wire ts_wrap = ts_adv & (ts_ff == `TTRC_TS_WRAP);
  wire force_ovf = i_ts_overflow_on & (ovf_pend_ff | ts_wrap) & ~rec_ok;
  wire stop_now = o_triggered_ff & (delay_cnt_ff <= 32'h00000001);

  // timestamp runs free of emulation start
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_ff <= 16'h0000;
      presc_phase_ff <= 1'b0;
      ts_ff <= 16'h0000;
    end else if (half_tick) begin
      presc_phase_ff <= ~presc_phase_ff | no_presc;
      if (!no_presc && presc_phase_ff)
        presc_ff <= (presc_ff == presc_top) ? 16'h0000 : presc_ff + 16'h0001;
      if (ts_adv)
        ts_ff <= ts_ff + 16'h0001;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_capturing_ff <= 1'b0;
      o_triggered_ff <= 1'b0;
      o_store_ff <= 1'b0;
      o_store_frame_ff <= 64'h0;
      o_break_req_ff <= 1'b0;
      o_loop_done_ff <= 1'b1;
      o_state_bits_ff <= 6'h00;
      o_cycle_count_ff <= 32'h00000000;
      o_cycle_gate_pin_ff <= 1'b0;
      chain_step_ff <= 2'h0;
      rec_expr_d_ff <= 1'b0;
      filt_cnt_ff <= 4'h0;
      delay_cnt_ff <= `TTRC_DELAY_DFLT;
      loop_cnt_ff <= `TTRC_LOOP_DFLT;
      ovf_pend_ff <= 1'b0;
    end else if (i_emu_start) begin
      o_capturing_ff <= 1'b1;
      o_triggered_ff <= 1'b0;
      o_store_ff <= 1'b0;
      o_break_req_ff <= 1'b0;
      chain_step_ff <= 2'h0;
      filt_cnt_ff <= 4'h0;
      rec_expr_d_ff <= 1'b0;
      ovf_pend_ff <= 1'b0;
      o_state_bits_ff <= 6'h00;
      o_cycle_gate_pin_ff <= 1'b0;
      o_cycle_count_ff <= 32'h00000000;
      delay_cnt_ff <= i_trig_delay;
      loop_cnt_ff <= i_loop_count;
      o_loop_done_ff <= (i_loop_count == 16'h0000);
    end else begin
      o_store_ff <= 1'b0;
      o_break_req_ff <= 1'b0;
      // set wins: a wrap in the clearing cycle stays pending
      if (ts_wrap)
        ovf_pend_ff <= 1'b1;
      else if (frame_tick && o_capturing_ff)
        ovf_pend_ff <= 1'b0;
      if (frame_tick && o_capturing_ff) begin
        o_state_bits_ff <= nxt_sbits;
        o_cycle_gate_pin_ff <= nxt_sbits[`TTRC_SB_CYCLE];
        if (o_state_bits_ff[`TTRC_SB_CYCLE])
          o_cycle_count_ff <= o_cycle_count_ff + 32'h00000001;
        if (nxt_sbits[`TTRC_SB_LOOP] && !o_state_bits_ff[`TTRC_SB_LOOP] &&
            loop_cnt_ff != 16'h0000) begin
          loop_cnt_ff <= loop_cnt_ff - 16'h0001;
          o_loop_done_ff <= (loop_cnt_ff == 16'h0001);
        end
        // advance to the next step on a later frame
        if (i_trig_on && !o_triggered_ff && step_true &&
            chain_step_ff != i_trig_last_step)
          chain_step_ff <= chain_step_ff + 2'h1;
        rec_expr_d_ff <= rec_expr;
        if (rec_expr)
          filt_cnt_ff <= 4'h0;
        else if (rec_expr_d_ff)
          filt_cnt_ff <= (i_filter_delay == 4'h0) ? 4'h0 :
            i_filter_delay - 4'h1;
        else if (filt_cnt_ff != 4'h0)
          filt_cnt_ff <= filt_cnt_ff - 4'h1;
        if (rec_ok || force_ovf) begin
          o_store_ff <= 1'b1;
          o_store_frame_ff <= {ts_ff, frame};
        end
        if (trig_now) begin
          o_triggered_ff <= 1'b1;
          if (i_break_mode == `TTRC_BRK_TRIG)
            o_break_req_ff <= 1'b1;
        end
        if (o_triggered_ff) begin
          delay_cnt_ff <= delay_cnt_ff - 32'h00000001;
          if (stop_now) begin
            o_capturing_ff <= 1'b0;
            if (i_break_mode == `TTRC_BRK_DONE)
              o_break_req_ff <= 1'b1;
          end
        end
        if (i_break_mode == `TTRC_BRK_STATE &&
            nxt_sbits[`TTRC_SB_BREAK] && !o_state_bits_ff[`TTRC_SB_BREAK])
          o_break_req_ff <= 1'b1;
      end
    end
  end

endmodule // ttrc_trace_ctrl

// [dv/ttrc_checker.sv]
// Purpose: port assertions of the trace control block
// Assumes: configuration changes only while no frames are in flight
// Notes: all checks are disabled while reset is low
`timescale 1ns/100ps
`include "ttrc_defs.vh"
module ttrc_checker (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_emu_start,
  input wire i_trig_on,
  input wire [1:0] i_break_mode,
  input wire o_capturing_ff,
  input wire o_triggered_ff,
  input wire o_store_ff,
  input wire o_break_req_ff,
  input wire [5:0] o_state_bits_ff,
  input wire [31:0] o_cycle_count_ff,
  input wire o_cycle_gate_pin_ff
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_store_one_cycle: assert property (o_store_ff |=> !o_store_ff)
    else $error("store pulse longer than one cycle");
  chk_store_when_live: assert property (o_store_ff |-> $past(o_capturing_ff))
    else $error("store while not capturing");
  chk_trig_needs_on: assert property ($rose(o_triggered_ff) |-> $past(i_trig_on))
    else $error("trigger while trigger off");
  chk_trig_break: assert property ($rose(o_triggered_ff) &&
    i_break_mode == `TTRC_BRK_TRIG |-> o_break_req_ff)
    else $error("no break at trigger");
  chk_done_break: assert property ($fell(o_capturing_ff) &&
    i_break_mode == `TTRC_BRK_DONE |-> o_break_req_ff)
    else $error("no break when capture stops");
  chk_break_one_cycle: assert property (o_break_req_ff |=> !o_break_req_ff)
    else $error("break pulse longer than one cycle");
  chk_gate_pin_follows: assert property (o_cycle_gate_pin_ff == o_state_bits_ff[5])
    else $error("gate pin differs from state bit five");
  chk_cycle_step_one: assert property ($changed(o_cycle_count_ff) &&
    !$past(i_emu_start) |-> o_cycle_count_ff == $past(o_cycle_count_ff) + 32'h1)
    else $error("cycle counter jumped");
  cover property ($rose(o_triggered_ff));
  cover property ($fell(o_capturing_ff));
  cover property (o_store_ff);
endmodule // ttrc_checker

// [dv/ttrc_pod_model.sv]
// Purpose: pod model presenting one frame per target memory cycle
// Assumes: strobe and data are async pins of the block
// Notes: released data lines show the inverse, never the old frame
`timescale 1ns/100ps
module ttrc_pod_model (
  input wire i_clk,
  output reg o_strobe,
  output reg [47:0] o_data,
  output reg o_src,
  output reg o_half
);
  initial begin
    o_strobe = 0;
    o_data = 48'h0;
    o_src = 0;
    o_half = 0;
  end
  // half-cycle ticks run free, as the target clock does
  always begin
    repeat (3) @(posedge i_clk);
    #1 o_half = ~o_half;
  end
  task send(input [47:0] x, input s);
    begin
      @(posedge i_clk);
      #1 o_data = x;
      o_src = s;
      repeat (4) @(posedge i_clk);
      #1 o_strobe = 1;
      repeat (4) @(posedge i_clk);
      #1 o_strobe = 0;
      o_data = ~x;
      o_src = ~s;
      repeat (2) @(posedge i_clk);
      // hand back off the edge so callers never race the clock
      #1;
    end
  endtask
endmodule // ttrc_pod_model

// [dv/tb_top.sv]
// Purpose: self-checking bench of the trace control block
// Assumes: state-bit terms all-true until the chain run
// Notes: expected stores queue up in frame order
`timescale 1ns/100ps
`include "ttrc_defs.vh"
module tb_top;
  reg clk, rst_n, emu, trig_on, ovf;
  reg [1:0] brk, rec;
  reg [383:0] care, val;
  reg [3:0] fdly;
  reg [59:0] rt;
  reg [119:0] tt;
  reg [31:0] dly;
  reg [16:0] pre;
  reg [5:0] sclr;
  reg [179:0] sta, stb;
  reg [1:0] lst;
  reg [15:0] lcnt;
  wire strobe, src, half, cap, trg, st, brq, ldone, gate;
  wire [47:0] fdata;
  wire [63:0] sfrm;
  wire [5:0] sbits;
  wire [31:0] ccnt;
  reg [47:0] expq[$];
  reg [47:0] e;
  integer num_errors, samples_checked, nbrk, cyc, i, b;
  integer hcnt, hprev, tse, dts;
  ttrc_pod_model u_pod (.i_clk(clk), .o_strobe(strobe), .o_data(fdata),
    .o_src(src), .o_half(half));
  ttrc_trace_ctrl DUT (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_frame_strobe(strobe), .i_frame_data(fdata), .i_frame_is_source(src),
    .i_half_cycle(half), .i_emu_start(emu), .i_evt_care(care),
    .i_evt_value(val), .i_sbit_setclr(sclr), .i_sbit_term_a(sta),
    .i_sbit_term_b(stb), .i_trig_on(trig_on), .i_trig_last_step(lst),
    .i_trig_terms(tt), .i_trig_delay(dly), .i_loop_count(lcnt),
    .i_break_mode(brk), .i_record_mode(rec), .i_record_terms(rt),
    .i_filter_delay(fdly), .i_ts_prescale(pre), .i_ts_overflow_on(ovf),
    .o_capturing_ff(cap), .o_triggered_ff(trg), .o_store_ff(st),
    .o_store_frame_ff(sfrm), .o_break_req_ff(brq), .o_loop_done_ff(ldone),
    .o_state_bits_ff(sbits), .o_cycle_count_ff(ccnt),
    .o_cycle_gate_pin_ff(gate));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task complete_run;
    begin
      if (num_errors == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [95:0] n, input [47:0] x, input [47:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s exp %h got %h", n, x, g);
      end
    end
  endtask
  // store watcher takes the oldest note on each store pulse
  always @(negedge clk) begin
    if (!rst_n) begin
      hcnt = 0;
      hprev = 0;
    end else begin
      if (half && hprev == 0)
        hcnt = hcnt + 1;
      hprev = half;
    end
    if (st) begin
      e = (expq.size() > 0) ? expq.pop_front() : 48'hx;
      chk("store_frame", e, sfrm[47:0]);
      // one half tick may still sit in the synchroniser
      tse = hcnt / ((pre < 17'h00002) ? 1 : pre);
      dts = tse - sfrm[63:48];
      samples_checked = samples_checked + 1;
      if (dts < 0 || dts > 1) begin
        num_errors = num_errors + 1;
        $display("mismatch timestamp exp %0d got %0d", tse, sfrm[63:48]);
      end
    end
    if (brq) nbrk = nbrk + 1;
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  task start;
    begin
      @(posedge clk);
      #1 emu = 1;
      @(posedge clk);
      #1 emu = 0;
    end
  endtask
  task frm(input s, input b0, input x);
    reg [47:0] d;
    begin
      d = {$urandom, $urandom};
      d[0] = b0;
      if (x) expq.push_back(d);
      u_pod.send(d, s);
    end
  endtask
  initial begin
    rst_n = 0; emu = 0; trig_on = 0; brk = 0; rec = 0; fdly = 0;
    care = 384'h1; val = 384'h1; tt = 120'h0; dly = 32'h2; ovf = 1;
    sclr = 6'h00; sta = 180'h0; stb = 180'h0; lst = 2'h0; lcnt = 16'h0000;
    // no chaining in the record expression
    rt = {2{30'h00008001}};
    num_errors = 0; samples_checked = 0; nbrk = 0; cyc = 0;
    void'($urandom(24));
    // small even divisors keep the timestamp moving within the run
    pre = 17'h00002 * ($urandom % 4);
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    chk("cap_rst", 0, cap);
    chk("ldone_rst", 1, ldone);
    trig_on = 1;
    for (b = 0; b < 4; b = b + 1) begin
      brk = b;
      start;
      nbrk = 0;
      for (i = 0; i < 4; i = i + 1) frm(0, i[0], i < 3);
      chk("breaks", b != 0, nbrk);
      chk("cap_stop", 0, cap);
      chk("trig", 1, trg);
      chk("cycles", 2, ccnt);
      chk("gate", 1, gate);
    end
    // chain: bit0 high, then bit0 low at a later frame; loop on bit3
    brk = 0;
    lst = 2'h1;
    tt = {60'h0, 30'h00008000, 30'h00008001};
    lcnt = 16'h0002;
    sclr = 6'h01;
    // bit0 set on bit0 high, clear never true; bit3 follows bit0
    sta = {60'h0, 30'h00008001, 60'h0, 30'h00008001};
    stb = {60'h0, 30'h00008001, 60'h0, 30'h00010000};
    start;
    frm(0, 0, 1);
    frm(0, 1, 1);
    frm(0, 1, 1);
    chk("chain_wait", 0, trg);
    frm(0, 0, 1);
    chk("chain_trig", 1, trg);
    chk("setclr_hold", 1, sbits[0]);
    chk("loop_early", 0, ldone);
    frm(0, 1, 1);
    chk("loop_done", 1, ldone);
    frm(0, 0, 1);
    chk("chain_stop", 0, cap);
    trig_on = 0;
    brk = 0;
    rec = 2;
    start;
    for (i = 0; i < 4; i = i + 1) frm(i[0], 1, i[0]);
    rec = 1;
    fdly = 1;
    start;
    frm(0, 1, 1);
    frm(0, 0, 1);
    frm(0, 0, 0);
    frm(0, 1, 1);
    chk("trig_off", 0, trg);
    chk("queue_left", 0, expq.size());
    complete_run;
  end
endmodule // tb_top
bind ttrc_trace_ctrl ttrc_checker u_chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_emu_start(i_emu_start), .i_trig_on(i_trig_on),
  .i_break_mode(i_break_mode), .o_capturing_ff(o_capturing_ff),
  .o_triggered_ff(o_triggered_ff), .o_store_ff(o_store_ff),
  .o_break_req_ff(o_break_req_ff), .o_state_bits_ff(o_state_bits_ff),
  .o_cycle_count_ff(o_cycle_count_ff),
  .o_cycle_gate_pin_ff(o_cycle_gate_pin_ff));
